// ===== mmu_checker.sv
// Concurrent checks on the translation unit's ports.
// Assumes binding to mmu_top on aclk with aresetn low as reset.
`timescale 1ns/1ps
`default_nettype none
module mmu_checker
    import mmu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Translation
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_vaddr,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] rsp_paddr,
    input wire logic rsp_cached,
    input wire logic rsp_miss,
    input wire logic rsp_addr_err,
    // Mode
    input wire logic exc_take,
    input wire logic exception_return,
    input wire logic kernel_mode,
    // Bus responses
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers come exactly one cycle after each request
    chk_rsp_one_cycle: assert property (req_valid |=> rsp_valid)
        else $error("translation answer missing");
    chk_exc_kernel: assert property (exc_take |=> kernel_mode)
        else $error("exception did not enter kernel mode");
    chk_kernel_hold: assert property (kernel_mode && !exception_return |=> kernel_mode)
        else $error("kernel mode left without return");
    chk_user_upper_err: assert property (req_valid && !kernel_mode && req_vaddr[31] |=> rsp_addr_err)
        else $error("user access to upper half not refused");
    chk_kernel_no_err: assert property (req_valid && kernel_mode |=> !rsp_addr_err)
        else $error("kernel access refused");
    // Direct segments skip the buffer onto physical 0 to 512 MB
    chk_cached_direct: assert property (req_valid && kernel_mode && req_vaddr[31:29] == SEG_CACHED
        |=> rsp_cached && !rsp_miss && rsp_paddr == {DIRECT_BASE, $past(req_vaddr[28:0])})
        else $error("cached direct segment mistranslated");
    chk_uncached_direct: assert property (req_valid && kernel_mode && req_vaddr[31:29] == SEG_UNCACHED
        |=> !rsp_cached && !rsp_miss && rsp_paddr == {DIRECT_BASE, $past(req_vaddr[28:0])})
        else $error("uncached direct segment mistranslated");
    chk_miss_uncached: assert property (rsp_valid && rsp_miss |-> !rsp_cached)
        else $error("missed access marked cacheable");
    chk_err_uncached: assert property (rsp_valid && rsp_addr_err |-> !rsp_cached)
        else $error("refused access marked cacheable");
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    cov_miss: cover property (rsp_valid && rsp_miss);
    cov_addr_err: cover property (rsp_valid && rsp_addr_err);
    cov_exc: cover property (exc_take ##[1:20] exception_return);
    cov_user_req: cover property (req_valid && !kernel_mode);
endmodule
bind mmu_top mmu_checker mmu_checker_inst (.aclk, .aresetn, .req_valid, .req_vaddr, .rsp_valid, .rsp_paddr,
    .rsp_cached, .rsp_miss, .rsp_addr_err, .exc_take, .exception_return, .kernel_mode, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ===== mmu_pkg.sv
// Package for the address translation unit: segment bounds, field layout,
// register map of the AXI4-Lite slave, status bits and reset values.
// Assumes a 32-bit address space and 4 KB pages.
package mmu_pkg;
    localparam int ADDR_W = 32;
    localparam int PAGE_BITS = 12;
    localparam int VPN_W = 20;
    localparam int TAG_W = 6;
    localparam int ENTRIES = 64;
    localparam int IDX_W = 6;
    // Segment decode on the top three address bits
    localparam logic [2:0] SEG_CACHED = 3'h4;
    localparam logic [2:0] SEG_UNCACHED = 3'h5;
    localparam logic [2:0] DIRECT_BASE = 3'h0;
    // Upper half word layout: page field at [31:12], tag at [11:6]
    localparam int HI_TAG_LSB = 6;
    // Lower half word layout: frame [31:12], uncached 11, writable 10, valid 9, global 8
    localparam int LO_NC_BIT = 11;
    localparam int LO_WR_BIT = 10;
    localparam int LO_VALID_BIT = 9;
    localparam int LO_GLOBAL_BIT = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_INDEX = 8'h00;
    localparam logic [7:0] OFF_RANDOM = 8'h04;
    localparam logic [7:0] OFF_UPPER = 8'h08;
    localparam logic [7:0] OFF_LOWER = 8'h0C;
    localparam logic [7:0] OFF_CMD = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1C;
    localparam logic [7:0] OFF_BADADDR = 8'h20;
    localparam logic [7:0] OFF_REVISION = 8'h24;
    // Command register bits
    localparam int CMD_READ = 0;
    localparam int CMD_WRITE_IDX = 1;
    localparam int CMD_WRITE_RND = 2;
    localparam int CMD_PROBE = 3;
    // Status bits: miss, address error, write to read-only page
    localparam int ST_MISS = 0;
    localparam int ST_ADDR_ERR = 1;
    localparam int ST_MOD = 2;
    localparam int ST_W = 3;
    // Probe failure flag lives in index bit 31
    localparam int IDX_PROBE_FAIL = 31;
    localparam logic [IDX_W-1:0] RANDOM_RESET = 6'h3F;
    localparam logic [IDX_W-1:0] RANDOM_LOW = 6'h08;
    localparam logic [31:0] REVISION_DEFAULT = 32'h0000_0A5A; // arbitrary value
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== mmu_top.sv
// Address translation unit: 64-entry fully associative translation buffer,
// segment decode, kernel/user mode tracking and an AXI4-Lite register slave.
// Assumes the pipeline presents one address per cycle with a strobe and the
// exception logic pulses exception and return events on aclk.
// Notes on behaviour
// - The buffer holds 64 entries, searched all at once, each mapping one 4 KB page.
// - Lookup compares the current process tag and address bits 31:12 with each entry.
// - A hit replaces the page field by the frame field; a global entry ignores the tag.
// - Each entry carries writable, uncached and tag controls applied to every access.
// - A miss is only signalled; software refills, using the random pointer slot.
// - A pseudo-random pointer names the entry for replacement writes.
// - A software-written index pointer names the entry for indexed reads and writes.
// - The revision register is read-only and ignores writes.
// - Any exception puts the unit into kernel mode.
// - Kernel mode holds until the exception return restores the previous mode.
// - The lower 2 GB is open to both modes, the upper 2 GB to kernel only.
// - Every user segment address goes through the buffer with the 6-bit tag added.
// - Kernel accesses to the user segment translate just as in user mode.
// - The cached direct segment skips the buffer, is cached, maps to physical 0-512 MB.
// - The uncached direct segment skips buffer and cache, onto the same 512 MB.
// - The mapped kernel segment goes through the buffer in kernel mode; cacheability follows the entry.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mmu_top
    import mmu_pkg::*;
#(
    parameter logic [31:0] REVISION = REVISION_DEFAULT
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Translation request from the pipeline
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_vaddr,
    input wire logic req_write,
    // Translation answer, one cycle after the request
    output logic rsp_valid,
    output logic [ADDR_W-1:0] rsp_paddr,
    output logic rsp_cached,
    output logic rsp_miss,
    output logic rsp_addr_err,
    output logic rsp_mod_err,
    // Exception events from the pipeline
    input wire logic exc_take,
    input wire logic exception_return,
    output logic kernel_mode,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);
    // Translation buffer storage
    logic [VPN_W-1:0] vpn_q [ENTRIES];
    logic [TAG_W-1:0] tag_q [ENTRIES];
    logic [VPN_W-1:0] pfn_q [ENTRIES];
    logic [ENTRIES-1:0] glob_q, nc_q, wr_q, val_q;
    // Software-visible registers
    logic [IDX_W-1:0] index_q;
    logic probe_fail_q;
    logic [IDX_W-1:0] random_q;
    logic [31:0] upper_q, lower_q, badaddr_q;
    logic [3:0] status_q, mask_q;
    logic kernel_q, prev_kernel_q;
    // Bus holding registers
    logic aw_full_q, w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Current process tag sits in the upper half register
    wire [TAG_W-1:0] cur_tag = upper_q[HI_TAG_LSB +: TAG_W];
    wire [VPN_W-1:0] req_vpn = req_vaddr[ADDR_W-1 -: VPN_W];
    wire [VPN_W-1:0] upper_vpn = upper_q[ADDR_W-1 -: VPN_W];

    // Parallel compare, a lookup and a probe comparator per entry
    logic [ENTRIES-1:0] hit_vec, probe_vec;
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_cmp
            assign hit_vec[g] = val_q[g] && vpn_q[g] == req_vpn
                && (glob_q[g] || tag_q[g] == cur_tag);
            assign probe_vec[g] = vpn_q[g] == upper_vpn && (glob_q[g] || tag_q[g] == cur_tag);
        end
    endgenerate

    // Priority encode; software must keep entries unique
    logic [IDX_W-1:0] hit_idx, probe_idx;
    always_comb begin
        hit_idx = '0;
        probe_idx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_idx = IDX_W'(i);
            end
            if (probe_vec[i]) begin
                probe_idx = IDX_W'(i);
            end
        end
    end

    // Segment decode on the top address bits
    wire [2:0] seg = req_vaddr[ADDR_W-1 -: 3];
    wire in_user_seg = !req_vaddr[ADDR_W-1];
    wire seg_cached = seg == SEG_CACHED;
    wire seg_uncached = seg == SEG_UNCACHED;
    wire seg_direct = seg_cached || seg_uncached;
    wire addr_err = !kernel_q && !in_user_seg;
    // User and mapped kernel segments both take the buffer path
    wire mapped = !seg_direct;
    wire any_hit = |hit_vec;
    wire mod_err = any_hit && req_write && !wr_q[hit_idx];
    wire [ADDR_W-1:0] direct_pa = {DIRECT_BASE, req_vaddr[ADDR_W-4:0]};
    wire [ADDR_W-1:0] mapped_pa = {pfn_q[hit_idx], req_vaddr[PAGE_BITS-1:0]};
    wire miss_ev = req_valid && !addr_err && mapped && !any_hit;
    wire aerr_ev = req_valid && addr_err;
    wire mod_ev = req_valid && !addr_err && mapped && mod_err;

    // Translation answer register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_valid <= 1'b0;
            rsp_paddr <= '0;
            rsp_cached <= 1'b0;
            rsp_miss <= 1'b0;
            rsp_addr_err <= 1'b0;
            rsp_mod_err <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
            rsp_paddr <= mapped ? mapped_pa : direct_pa;
            // A refused access must never be reported as cacheable
            rsp_cached <= !addr_err
                && (seg_cached || (mapped && any_hit && !nc_q[hit_idx]));
            rsp_miss <= miss_ev;
            rsp_addr_err <= aerr_ev;
            rsp_mod_err <= mod_ev;
        end
    end

    // Bus write decode
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [7:0] wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_full_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_full_q ? w_strb_q : s_axi_wstrb;
    wire have_aw = aw_full_q || aw_take;
    wire have_w = w_full_q || w_take;
    wire wr_fire = have_aw && have_w && !s_axi_bvalid;
    wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_known = wr_addr == OFF_INDEX || wr_addr == OFF_RANDOM || wr_addr == OFF_UPPER
        || wr_addr == OFF_LOWER || wr_addr == OFF_CMD || wr_addr == OFF_MODE
        || wr_addr == OFF_STATUS || wr_addr == OFF_MASK || wr_addr == OFF_BADADDR
        || wr_addr == OFF_REVISION;
    wire we_index = wr_fire && wr_addr == OFF_INDEX;
    wire we_upper = wr_fire && wr_addr == OFF_UPPER;
    wire we_lower = wr_fire && wr_addr == OFF_LOWER;
    wire we_cmd = wr_fire && wr_addr == OFF_CMD;
    wire we_status = wr_fire && wr_addr == OFF_STATUS;
    wire we_mask = wr_fire && wr_addr == OFF_MASK;
    wire [31:0] cmd = we_cmd ? (wr_data & strb_mask) : '0;
    // Random and revision writes are dropped on purpose
    wire [31:0] merged = wr_data & strb_mask;
    wire we_mode = wr_fire && wr_addr == OFF_MODE;

    // Mode tracking: exception wins over a return in the same cycle; software
    // presets only the previous mode, so kernel mode still holds until a return
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kernel_q <= 1'b1;
            prev_kernel_q <= 1'b1;
        end else if (exc_take) begin
            kernel_q <= 1'b1;
            prev_kernel_q <= kernel_q;
        end else if (exception_return) begin
            kernel_q <= prev_kernel_q;
        end else if (we_mode) begin
            prev_kernel_q <= merged[1];
        end
    end
    assign kernel_mode = kernel_q;

    // Write channel holding; both channels accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            aw_full_q <= have_aw && !wr_fire;
            w_full_q <= have_w && !wr_fire;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;

    // Pointer registers; random counts down, wrapping above the low bound
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index_q <= '0;
            probe_fail_q <= 1'b0;
            random_q <= RANDOM_RESET;
        end else begin
            random_q <= (random_q <= RANDOM_LOW) ? RANDOM_RESET : random_q - 1'b1;
            if (cmd[CMD_PROBE]) begin
                index_q <= probe_idx;
                probe_fail_q <= !(|probe_vec);
            end else if (we_index) begin
                index_q <= merged[IDX_W-1:0];
                probe_fail_q <= merged[IDX_PROBE_FAIL];
            end
        end
    end

    // Entry staging registers; an indexed read loads them from the buffer
    wire [VPN_W-1:0] rd_vpn = vpn_q[index_q];
    wire [TAG_W-1:0] rd_tag = tag_q[index_q];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_q <= '0;
            lower_q <= '0;
        end else if (cmd[CMD_READ]) begin
            upper_q <= {rd_vpn, rd_tag, {HI_TAG_LSB{1'b0}}};
            lower_q <= {pfn_q[index_q], nc_q[index_q], wr_q[index_q], val_q[index_q],
                glob_q[index_q], 8'h00};
        end else begin
            if (we_upper) begin
                upper_q <= (upper_q & ~strb_mask) | merged;
            end
            if (we_lower) begin
                lower_q <= (lower_q & ~strb_mask) | merged;
            end
        end
    end

    // Buffer writes through index or random pointer
    wire ent_we = cmd[CMD_WRITE_IDX] || cmd[CMD_WRITE_RND];
    wire [IDX_W-1:0] ent_sel = cmd[CMD_WRITE_RND] ? random_q : index_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            val_q <= '0;
            glob_q <= '0;
            nc_q <= '0;
            wr_q <= '0;
        end else if (ent_we) begin
            val_q[ent_sel] <= lower_q[LO_VALID_BIT];
            glob_q[ent_sel] <= lower_q[LO_GLOBAL_BIT];
            nc_q[ent_sel] <= lower_q[LO_NC_BIT];
            wr_q[ent_sel] <= lower_q[LO_WR_BIT];
        end
    end
    // Field arrays carry no reset; valid bits guard lookups but not probes
    always_ff @(posedge aclk) begin
        if (ent_we) begin
            vpn_q[ent_sel] <= upper_vpn;
            tag_q[ent_sel] <= cur_tag;
            pfn_q[ent_sel] <= lower_q[ADDR_W-1 -: VPN_W];
        end
    end

    // Sticky status, mask and faulting address; set beats clear
    wire [3:0] ev_vec = {1'b0, mod_ev, aerr_ev, miss_ev};
    wire [3:0] clr_vec = we_status ? merged[ST_W-1+1:0] : 4'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
            mask_q <= '0;
            badaddr_q <= '0;
            irq <= 1'b0;
        end else begin
            status_q <= (status_q & ~clr_vec) | ev_vec;
            if (we_mask) begin
                mask_q <= merged[ST_W-1+1:0];
            end
            if (miss_ev || aerr_ev || mod_ev) begin
                badaddr_q <= req_vaddr;
            end
            irq <= |(((status_q & ~clr_vec) | ev_vec) & mask_q);
        end
    end

    // Read path: address taken, data answered one cycle later
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        unique case (s_axi_araddr)
            OFF_INDEX: rd_mux = {probe_fail_q, {(31-IDX_W){1'b0}}, index_q};
            OFF_RANDOM: rd_mux = {{(32-IDX_W){1'b0}}, random_q};
            OFF_UPPER: rd_mux = upper_q;
            OFF_LOWER: rd_mux = lower_q;
            OFF_CMD: rd_mux = '0;
            OFF_MODE: rd_mux = {30'h0, prev_kernel_q, kernel_q};
            OFF_STATUS: rd_mux = {28'h0, status_q};
            OFF_MASK: rd_mux = {28'h0, mask_q};
            OFF_BADADDR: rd_mux = badaddr_q;
            OFF_REVISION: rd_mux = REVISION;
            default: begin
                rd_mux = '0;
                rd_known = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

// ===== pipe_model.sv
// Pipeline stand-in: presents addresses and exception events.
// Assumes the unit answers one cycle after a request.
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
    // Clock
    input wire logic aclk,
    // Requests and events
    output logic req_valid,
    output logic [31:0] req_vaddr,
    output logic req_write,
    output logic exc_take,
    output logic exception_return
);
    initial begin
        req_valid = 1'b0;
        req_vaddr = 32'h0;
        req_write = 1'b0;
        exc_take = 1'b0;
        exception_return = 1'b0;
    end
    // One request; the released address is inverted so stale values show
    task automatic xlate(input logic [31:0] a, input logic w);
        @(posedge aclk);
        req_valid <= 1'b1;
        req_vaddr <= a;
        req_write <= w;
        @(posedge aclk);
        req_valid <= 1'b0;
        req_vaddr <= ~a;
        #1;
    endtask
    // One-cycle event pulse: exception or return
    task automatic event_pulse(input logic ret);
        @(posedge aclk);
        exc_take <= !ret;
        exception_return <= ret;
        @(posedge aclk);
        exc_take <= 1'b0;
        exception_return <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the translation unit over AXI4-Lite.
// Assumes pipe_model drives the request side; checker bound separately.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mmu_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, e;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, kernel_mode;
    logic [1:0] bresp, rresp, r;
    logic req_valid, req_write, exc_take, exception_return;
    logic [31:0] req_vaddr, rsp_paddr;
    logic rsp_valid, rsp_cached, rsp_miss, rsp_addr_err, rsp_mod_err;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    always #4 aclk = ~aclk;
    mmu_top mmu_top_inst (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req_vaddr(req_vaddr),
        .req_write(req_write), .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr), .rsp_cached(rsp_cached),
        .rsp_miss(rsp_miss), .rsp_addr_err(rsp_addr_err), .rsp_mod_err(rsp_mod_err), .exc_take(exc_take),
        .exception_return(exception_return), .kernel_mode(kernel_mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    pipe_model pipe_model_inst (.aclk(aclk), .req_valid(req_valid), .req_vaddr(req_vaddr),
        .req_write(req_write), .exc_take(exc_take), .exception_return(exception_return));
    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        logic b_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Local flags, since the valid variables update only after this time step
        while (!b_done) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                b_done = 1'b1;
                bready <= 1'b0;
            end
        end
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        rd(a);
        chk(d, v);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wr_entry(input logic [31:0] i, input logic [31:0] up, input logic [31:0] lo,
            input logic [31:0] cmd);
        wc(OFF_INDEX, i, RESP_OKAY);
        wc(OFF_UPPER, up, RESP_OKAY);
        wc(OFF_LOWER, lo, RESP_OKAY);
        wc(OFF_CMD, cmd, RESP_OKAY);
    endtask
    // Flags are {cached, miss, addr_err, mod_err}; address checked when neither miss nor addr_err is expected
    task automatic xl(input logic [31:0] a, input logic w, input logic [31:0] p, input logic [3:0] f);
        pipe_model_inst.xlate(a, w);
        chk({28'h0, rsp_cached, rsp_miss, rsp_addr_err, rsp_mod_err}, {28'h0, f});
        if (f[2:1] == 2'b00) chk(rsp_paddr, p);
    endtask
    task automatic settle;
        @(posedge aclk);
        #1;
    endtask
    // Hang guard, well above the 150 or so cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rc(OFF_INDEX, 32'h0, RESP_OKAY);
        rc(OFF_MASK, 32'h0, RESP_OKAY);
        wc(OFF_REVISION, 32'hFFFF_FFFF, RESP_OKAY);
        rc(OFF_REVISION, REVISION_DEFAULT, RESP_OKAY);
        wc(8'h40, 32'h1, RESP_SLVERR);
        rc(8'h40, 32'h0, RESP_SLVERR);
        wc(OFF_RANDOM, 32'h0, RESP_OKAY);
        rd(OFF_RANDOM);
        e = d;
        chk({31'h0, d >= 32'(RANDOM_LOW) && d <= 32'(RANDOM_RESET)}, 32'h1);
        rd(OFF_RANDOM);
        chk({31'h0, d != e}, 32'h1);
        rd(OFF_MODE);
        chk(d[0], 32'h1);
        xl(32'h8123_4567, 1'b0, 32'h0123_4567, 4'b1000);
        xl(32'hA123_4567, 1'b0, 32'h0123_4567, 4'b0000);
        // Miss, status, mask and interrupt
        xl(32'hC000_1234, 1'b0, 32'h0, 4'b0100);
        settle();
        chk(irq, 32'h0);
        wc(OFF_MASK, 32'h1, RESP_OKAY);
        settle();
        chk(irq, 32'h1);
        wc(OFF_STATUS, 32'h1, RESP_OKAY);
        settle();
        chk(irq, 32'h0);
        rc(OFF_STATUS, 32'h0, RESP_OKAY);
        // Last slot, read-only page, then indexed read back and probe
        wr_entry(32'h3F, 32'hC000_1000, 32'h1234_5200, 32'h2);
        xl(32'hC000_1ABC, 1'b0, 32'h1234_5ABC, 4'b1000);
        xl(32'hC000_1ABC, 1'b1, 32'h1234_5ABC, 4'b1001);
        wc(OFF_UPPER, 32'h0, RESP_OKAY);
        wc(OFF_CMD, 32'h1, RESP_OKAY);
        rc(OFF_UPPER, 32'hC000_1000, RESP_OKAY);
        rc(OFF_LOWER, 32'h1234_5200, RESP_OKAY);
        wc(OFF_INDEX, 32'h0, RESP_OKAY);
        wc(OFF_CMD, 32'h8, RESP_OKAY);
        rc(OFF_INDEX, 32'h3F, RESP_OKAY);
        // User segment entry with tag 3, uncached and writable
        wr_entry(32'h6, 32'h0040_00C0, 32'h0077_7E00, 32'h2);
        xl(32'h0040_0010, 1'b1, 32'h0077_7010, 4'b0000);
        wc(OFF_UPPER, 32'h0000_0100, RESP_OKAY);
        xl(32'h0040_0010, 1'b0, 32'h0, 4'b0100);
        // Global entry by random write, then looked up under tag 4
        wc(OFF_UPPER, 32'h0050_0040, RESP_OKAY);
        wc(OFF_LOWER, 32'h0088_8300, RESP_OKAY);
        wc(OFF_CMD, 32'h4, RESP_OKAY);
        wc(OFF_UPPER, 32'h0000_0100, RESP_OKAY);
        xl(32'h0050_0ABC, 1'b0, 32'h0088_8ABC, 4'b1000);
        xl(32'h0040_0010, 1'b1, 32'h0, 4'b0100);
        // Mode stack: preset previous mode to user, then a return drops to user
        pipe_model_inst.event_pulse(1'b0);
        chk(kernel_mode, 32'h1);
        pipe_model_inst.event_pulse(1'b1);
        chk(kernel_mode, 32'h1);
        wc(OFF_MODE, 32'h0, RESP_OKAY);
        rc(OFF_MODE, 32'h1, RESP_OKAY);
        pipe_model_inst.event_pulse(1'b1);
        chk(kernel_mode, 32'h0);
        xl(32'h8000_0000, 1'b0, 32'h0, 4'b0010);
        rc(OFF_BADADDR, 32'h8000_0000, RESP_OKAY);
        xl(32'h0050_0ABC, 1'b0, 32'h0088_8ABC, 4'b1000);
        pipe_model_inst.event_pulse(1'b0);
        chk(kernel_mode, 32'h1);
        rc(OFF_MODE, 32'h1, RESP_OKAY);
        wrap_up();
    end
endmodule
`default_nettype wire
